//--- hw/cso_defs.vh
// Constants for the core status and option register bank.
`ifndef CSO_DEFS_VH
`define CSO_DEFS_VH

// ****************************************
// Register locations
// ****************************************
`define CSO_STATUS_LOC      7'h03
`define CSO_OPTION_LOC      8'h81

// ****************************************
// Status register fields
// ****************************************
`define CSO_ST_INDIRECT     7
`define CSO_ST_DIRECT_HI    6
`define CSO_ST_DIRECT_LO    5
`define CSO_ST_TIMEOUT      4
`define CSO_ST_POWERDOWN    3
`define CSO_ST_ZERO         2
`define CSO_ST_DIGIT_CARRY  1
`define CSO_ST_CARRY        0
`define CSO_STATUS_RST      8'h18

// ****************************************
// Option register fields
// ****************************************
`define CSO_OP_PULLUP_DIS   7
`define CSO_OP_INT_EDGE     6
`define CSO_OP_T0_SOURCE    5
`define CSO_OP_T0_EDGE      4
`define CSO_OP_PRESC_ASSIGN 3
`define CSO_OP_RATE_HI      2
`define CSO_OP_RATE_LO      0
`define CSO_OPTION_RST      8'hff

// ****************************************
// Interrupt flag positions
// ****************************************
`define CSO_IF_TIMER0       2
`define CSO_IF_EXT_PIN      1
`define CSO_IF_PORT_CHANGE  0

// ****************************************
// Instruction operation codes
// ****************************************
`define CSO_OP_ADD          4'h0
`define CSO_OP_SUB          4'h1
`define CSO_OP_AND          4'h2
`define CSO_OP_IOR          4'h3
`define CSO_OP_XOR          4'h4
`define CSO_OP_RL           4'h5
`define CSO_OP_RR           4'h6
`define CSO_OP_CLEAR        4'h7
`define CSO_OP_SWAP         4'h8
`define CSO_OP_MOVE         4'h9

// ****************************************
// Pin synchroniser indices
// ****************************************
`define CSO_PIN_T0CLK       0
`define CSO_PIN_EXTINT      1

`endif

//--- hw/cso_core_status_option.v
// Core status register, option register, timer0 prescaler and interrupt flags.
`timescale 1ns/1ps
`include "cso_defs.vh"

// Contract
// - Flag-setting instruction to status blocks flag write.
// - Timeout and power-down bits ignore software writes.
// - Clear on status clears bank bits, sets zero.
// - Subtraction carries act as inverted borrows.
// - Subtract by adding two's complement.
// - Rotate loads carry with shifted-out bit.
// - Status mirrored at same location, all banks.
// - Option read/write, mirrored in banks 1, 3.
// - Bit 7 disables pull-ups, else follow latches.
// - Bit 6 picks external interrupt edge.
// - Bit 5 picks timer0 clock source.
// - Bit 4 picks counted external edge.
// - Bit 3 assigns prescaler to watchdog or timer0.
// - Rate gives timer0 2^(n+1), watchdog 2^n.
// - Undivided timer0 needs prescaler on watchdog.
// - Option resets to all ones.
// - Interrupt flags set regardless of enables.
module cso_core_status_option
#(
  parameter DATA_W = 8,
  parameter PORT_W = 8
)
(
  input  wire              i_core_clk,
  input  wire              i_nrst,
  input  wire [8:0]        i_reg_addr,
  input  wire [DATA_W-1:0] i_reg_wdata,
  input  wire              i_reg_we,
  output wire              o_reg_hit,
  output reg  [DATA_W-1:0] o_reg_rdata,
  input  wire              i_alu_valid,
  input  wire [3:0]        i_alu_op,
  input  wire [DATA_W-1:0] i_alu_file,
  input  wire [DATA_W-1:0] i_alu_w,
  input  wire              i_alu_dest_status,
  output reg  [DATA_W-1:0] o_alu_result,
  output reg               o_alu_done,
  input  wire              i_evt_wdt_clear,
  input  wire              i_evt_sleep,
  input  wire              i_evt_wdt_timeout,
  input  wire              i_instr_cycle_en,
  input  wire              i_wdt_osc_tick,
  input  wire              i_timer0_ext_clock_pin,
  input  wire              i_ext_interrupt_pin,
  input  wire              i_port_change,
  input  wire [PORT_W-1:0] i_port_latch,
  input  wire [2:0]        i_int_flag_clr,
  output wire [PORT_W-1:0] o_pullup_enable,
  output wire [8:0]        o_indirect_bank_base,
  output wire [8:0]        o_direct_bank_base,
  output wire [DATA_W-1:0] o_status,
  output wire [DATA_W-1:0] o_option,
  output wire [DATA_W-1:0] o_timer0_count,
  output reg               o_wdt_tick,
  output wire [2:0]        o_int_flags
);

  // ****************************************
  // Reset release
  // ****************************************
  reg  [1:0] rst_sync_reg;
  wire       rst_n = rst_sync_reg[1];

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // A pin level is accepted only once the second and third stages agree,
  // which filters a single-cycle glitch caught at the sampling edge.
  wire [1:0] pin_raw;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;

  assign pin_raw[`CSO_PIN_T0CLK]  = i_timer0_ext_clock_pin;
  assign pin_raw[`CSO_PIN_EXTINT] = i_ext_interrupt_pin;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_pin
      reg [2:0] sync_reg;
      reg       level_reg;

      always @(posedge i_core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync_reg  <= 3'h0;
          level_reg <= 1'b0;
        end
        else
        begin
          sync_reg <= {sync_reg[1:0], pin_raw[gi]};
          if (sync_reg[1] == sync_reg[2])
            level_reg <= sync_reg[2];
        end
      end

      assign pin_rise[gi]  = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;
      assign pin_fall[gi]  = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && level_reg;
    end
  endgenerate

  // ****************************************
  // Register decode
  // ****************************************
  reg  [DATA_W-1:0] status_reg;
  reg  [DATA_W-1:0] status_next;
  reg  [DATA_W-1:0] option_reg;
  wire              hit_status;
  wire              hit_option;

  assign hit_status = (i_reg_addr[6:0] == `CSO_STATUS_LOC);
  assign hit_option = (i_reg_addr[7:0] == `CSO_OPTION_LOC);
  assign o_reg_hit  = hit_status || hit_option;

  // ****************************************
  // Instruction result and flags
  // ****************************************
  reg  [DATA_W-1:0] alu_res;
  reg               alu_z;
  reg               alu_dc;
  reg               alu_c;
  reg               alu_sets_flags;
  reg  [DATA_W:0]   sum_full;
  reg  [4:0]        sum_low;
  reg  [DATA_W-1:0] addend;

  always @*
  begin
    alu_res        = i_alu_file;
    alu_c          = status_reg[`CSO_ST_CARRY];
    alu_dc         = status_reg[`CSO_ST_DIGIT_CARRY];
    alu_sets_flags = (i_alu_op <= `CSO_OP_CLEAR);
    // Subtraction adds the two's complement, so carry out means no borrow.
    addend         = (i_alu_op == `CSO_OP_SUB) ? ~i_alu_w : i_alu_w;
    sum_full       = {1'b0, i_alu_file} + {1'b0, addend} +
                     {{DATA_W{1'b0}}, (i_alu_op == `CSO_OP_SUB)};
    sum_low        = {1'b0, i_alu_file[3:0]} + {1'b0, addend[3:0]} +
                     {4'h0, (i_alu_op == `CSO_OP_SUB)};
    case (i_alu_op)
      `CSO_OP_ADD, `CSO_OP_SUB:
      begin
        alu_res        = sum_full[DATA_W-1:0];
        alu_c          = sum_full[DATA_W];
        alu_dc         = sum_low[4];
      end
      `CSO_OP_AND:
        alu_res = i_alu_file & i_alu_w;
      `CSO_OP_IOR:
        alu_res = i_alu_file | i_alu_w;
      `CSO_OP_XOR:
        alu_res = i_alu_file ^ i_alu_w;
      `CSO_OP_RL:
      begin
        alu_res        = {i_alu_file[DATA_W-2:0], status_reg[`CSO_ST_CARRY]};
        alu_c          = i_alu_file[DATA_W-1];
      end
      `CSO_OP_RR:
      begin
        alu_res        = {status_reg[`CSO_ST_CARRY], i_alu_file[DATA_W-1:1]};
        alu_c          = i_alu_file[0];
      end
      `CSO_OP_CLEAR:
        alu_res = {DATA_W{1'b0}};
      `CSO_OP_SWAP:
        alu_res = {i_alu_file[3:0], i_alu_file[DATA_W-1:4]};
      `CSO_OP_MOVE:
        alu_res = i_alu_w;
      default:
        alu_res = i_alu_file;
    endcase
    alu_z = ((i_alu_op == `CSO_OP_RL) || (i_alu_op == `CSO_OP_RR)) ?
            status_reg[`CSO_ST_ZERO] : (alu_res == {DATA_W{1'b0}});
  end

  // ****************************************
  // Status register
  // ****************************************
  // Rotates change only carry; the zero flag of a rotate keeps its value.
  always @*
  begin
    status_next = status_reg;
    if (i_reg_we && hit_status)
      status_next = {i_reg_wdata[7:5], status_reg[4:3], i_reg_wdata[2:0]};
    if (i_alu_valid)
    begin
      if (i_alu_dest_status)
      begin
        status_next[7:5] = alu_res[7:5];
        if (!alu_sets_flags)
          status_next[2:0] = alu_res[2:0];
      end
      if (alu_sets_flags)
      begin
        // The instruction's own flags replace the written bits.
        status_next[`CSO_ST_ZERO]        = alu_z;
        status_next[`CSO_ST_DIGIT_CARRY] = alu_dc;
        status_next[`CSO_ST_CARRY]       = alu_c;
      end
    end
    if (i_evt_wdt_clear)
      status_next[`CSO_ST_TIMEOUT:`CSO_ST_POWERDOWN] = 2'h3;
    if (i_evt_sleep)
      status_next[`CSO_ST_TIMEOUT:`CSO_ST_POWERDOWN] = 2'h2;
    if (i_evt_wdt_timeout)
      status_next[`CSO_ST_TIMEOUT] = 1'b0;
  end

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= `CSO_STATUS_RST;
    else
      status_reg <= status_next;
  end

  // ****************************************
  // Option register
  // ****************************************
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      option_reg <= `CSO_OPTION_RST;
    else if (i_reg_we && hit_option)
      option_reg <= i_reg_wdata;
  end

  // ****************************************
  // Read data and instruction result
  // ****************************************
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_reg_rdata  <= {DATA_W{1'b0}};
      o_alu_result <= {DATA_W{1'b0}};
      o_alu_done   <= 1'b0;
    end
    else
    begin
      if (hit_status)
        o_reg_rdata <= status_reg;
      else if (hit_option)
        o_reg_rdata <= option_reg;
      else
        o_reg_rdata <= {DATA_W{1'b0}};
      o_alu_done <= i_alu_valid;
      if (i_alu_valid)
        o_alu_result <= alu_res;
    end
  end

  // ****************************************
  // Timer0 source and shared prescaler
  // ****************************************
  wire              t0_ext_edge;
  wire              t0_src_tick;
  wire              presc_to_wdt;
  wire [2:0]        rate;
  wire [DATA_W-1:0] t0_mask;
  wire [DATA_W-1:0] wdt_mask;
  wire              presc_tick;
  wire              presc_done;
  reg  [DATA_W-1:0] presc_reg;
  reg  [DATA_W-1:0] timer0_reg;
  reg               t0_inc;

  assign t0_ext_edge  = option_reg[`CSO_OP_T0_EDGE] ? pin_fall[`CSO_PIN_T0CLK] :
                        pin_rise[`CSO_PIN_T0CLK];
  assign t0_src_tick  = option_reg[`CSO_OP_T0_SOURCE] ? t0_ext_edge :
                        i_instr_cycle_en;
  assign presc_to_wdt = option_reg[`CSO_OP_PRESC_ASSIGN];
  assign rate         = option_reg[`CSO_OP_RATE_HI:`CSO_OP_RATE_LO];
  assign t0_mask      = ({{(DATA_W-1){1'b0}}, 1'b1} << ({1'b0, rate} + 4'h1)) - 1'b1;
  assign wdt_mask     = ({{(DATA_W-1){1'b0}}, 1'b1} << rate) - 1'b1;
  assign presc_tick   = presc_to_wdt ? i_wdt_osc_tick : t0_src_tick;
  assign presc_done   = presc_to_wdt ? ((presc_reg & wdt_mask) == wdt_mask) :
                        ((presc_reg & t0_mask) == t0_mask);

  // A rate code of 7 on timer0 needs all eight prescaler bits, so the mask
  // shift to bit 8 wraps to zero minus one, that is all ones.
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_reg  <= {DATA_W{1'b0}};
      timer0_reg <= {DATA_W{1'b0}};
      o_wdt_tick <= 1'b0;
      t0_inc     <= 1'b0;
    end
    else
    begin
      t0_inc     <= 1'b0;
      o_wdt_tick <= 1'b0;
      if (presc_to_wdt && i_evt_wdt_clear)
        presc_reg <= {DATA_W{1'b0}};
      else if (presc_tick)
      begin
        if (presc_done)
          presc_reg <= {DATA_W{1'b0}};
        else
          presc_reg <= presc_reg + 1'b1;
        o_wdt_tick <= presc_to_wdt && presc_done;
        t0_inc     <= !presc_to_wdt && presc_done;
      end
      if (presc_to_wdt && t0_src_tick)
        t0_inc <= 1'b1;
      if (!presc_to_wdt && i_wdt_osc_tick)
        o_wdt_tick <= 1'b1;
      if (t0_inc)
        timer0_reg <= timer0_reg + 1'b1;
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  reg  [2:0] int_flag_reg;
  wire [2:0] int_set;

  assign int_set[`CSO_IF_TIMER0]      = t0_inc && (timer0_reg == {DATA_W{1'b1}});
  assign int_set[`CSO_IF_EXT_PIN]     = option_reg[`CSO_OP_INT_EDGE] ?
                                        pin_rise[`CSO_PIN_EXTINT] :
                                        pin_fall[`CSO_PIN_EXTINT];
  assign int_set[`CSO_IF_PORT_CHANGE] = i_port_change;

  // Setting wins over a clear in the same cycle so no event is lost.
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      int_flag_reg <= 3'h0;
    else
      int_flag_reg <= (int_flag_reg & ~i_int_flag_clr) | int_set;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_pullup_enable      = option_reg[`CSO_OP_PULLUP_DIS] ? {PORT_W{1'b0}} :
                                i_port_latch;
  assign o_indirect_bank_base = {status_reg[`CSO_ST_INDIRECT], 8'h00};
  assign o_direct_bank_base   = {status_reg[`CSO_ST_DIRECT_HI],
                                 status_reg[`CSO_ST_DIRECT_LO], 7'h00};
  assign o_status             = status_reg;
  assign o_option             = option_reg;
  assign o_timer0_count       = timer0_reg;
  assign o_int_flags          = int_flag_reg;

endmodule

//--- verif/cso_core_model.sv
// Core issue stage model that hands one instruction a cycle to the bank.
`timescale 1ns/1ps
module cso_core_model
(
  input  wire       i_core_clk,
  input  wire       i_nrst,
  input  wire       i_go,
  input  wire [3:0] i_op,
  input  wire [7:0] i_file,
  input  wire [7:0] i_w,
  input  wire       i_dest,
  output reg        o_valid,
  output reg  [3:0] o_op,
  output reg  [7:0] o_file,
  output reg  [7:0] o_w,
  output reg        o_dest
);
  // Idle operands flip every cycle so that nothing leans on a stale value.
  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_valid <= 1'b0;
      o_op    <= 4'h0;
      o_file  <= 8'h00;
      o_w     <= 8'h00;
      o_dest  <= 1'b0;
    end
    else
    begin
      o_valid <= i_go;
      o_op    <= i_op;
      o_file  <= i_go ? i_file : ~o_file;
      o_w     <= i_go ? i_w : ~o_w;
      o_dest  <= i_go & i_dest;
    end
  end
endmodule

//--- verif/cso_core_status_option_sva.sv
// Checker for the core status and option register bank ports.
`timescale 1ns/1ps
`include "cso_defs.vh"
module cso_sva
(
  input wire       i_core_clk,
  input wire       i_nrst,
  input wire [8:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire       i_reg_we,
  input wire [7:0] o_reg_rdata,
  input wire       i_alu_valid,
  input wire [3:0] i_alu_op,
  input wire [7:0] i_alu_file,
  input wire [7:0] i_alu_w,
  input wire       i_alu_dest_status,
  input wire [7:0] o_alu_result,
  input wire       i_evt_wdt_clear,
  input wire       i_evt_sleep,
  input wire       i_evt_wdt_timeout,
  input wire       i_port_change,
  input wire [7:0] i_port_latch,
  input wire [7:0] o_pullup_enable,
  input wire [8:0] o_indirect_bank_base,
  input wire [8:0] o_direct_bank_base,
  input wire [7:0] o_status,
  input wire [7:0] o_option,
  input wire [2:0] o_int_flags
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Hardware events also move status bits 4:3, so those cycles are left out.
  wire quiet = !(i_evt_wdt_clear | i_evt_sleep | i_evt_wdt_timeout);

  AST_OPT_RST: assert property ($rose(i_nrst) |-> o_option == 8'hff [*2])
    else $error("option not all ones after reset");
  AST_PULLUP: assert property (o_pullup_enable == (o_option[7] ? 8'h00 : i_port_latch))
    else $error("pull-up enables wrong");
  AST_BANKS: assert property ({o_indirect_bank_base, o_direct_bank_base} ==
    {o_status[7], 8'h00, o_status[6:5], 7'h00}) else $error("bank bases wrong");
  AST_TOPD_RO: assert property (i_reg_we && i_reg_addr[6:0] == 7'h03 && quiet
    && !i_alu_valid |=> $stable(o_status[4:3])) else $error("status bits 4:3 written");
  AST_ST_WR: assert property (i_reg_we && i_reg_addr[6:0] == 7'h03 && !i_alu_valid |=>
    {o_status[7:5], o_status[2:0]} == {$past(i_reg_wdata[7:5]), $past(i_reg_wdata[2:0])})
    else $error("status write lost");
  AST_OPT_WR: assert property (i_reg_we && i_reg_addr[7:0] == 8'h81 |=>
    o_option == $past(i_reg_wdata)) else $error("option write lost");
  AST_RD_OPT: assert property (!i_reg_we && i_reg_addr[7:0] == 8'h81 |=>
    o_reg_rdata == $past(o_option)) else $error("option read wrong");
  AST_CLEAR: assert property (i_alu_valid && i_alu_op == `CSO_OP_CLEAR && i_alu_dest_status
    && quiet && !i_reg_we |=> o_status == {3'b000, $past(o_status[4:3]), 1'b1,
    $past(o_status[1:0])}) else $error("clear of status wrong");
  AST_SUB: assert property (i_alu_valid && i_alu_op == `CSO_OP_SUB && !i_alu_dest_status
    |=> o_alu_result == $past(i_alu_file) - $past(i_alu_w)
    && o_status[0] == ($past(i_alu_file) >= $past(i_alu_w))
    && o_status[1] == ($past(i_alu_file[3:0]) >= $past(i_alu_w[3:0])))
    else $error("subtract result or borrow wrong");
  AST_ROT: assert property (i_alu_valid && i_alu_op == `CSO_OP_RL |=>
    {o_status[0], o_alu_result} == {$past(i_alu_file), $past(o_status[0])})
    else $error("rotate carry wrong");
  AST_TIMEOUT: assert property (i_evt_wdt_timeout |=> !o_status[4])
    else $error("timeout flag not cleared");
  AST_PORT_FLAG: assert property (i_port_change |=> o_int_flags[0])
    else $error("port change flag not set");
endmodule

bind cso_core_status_option cso_sva i_sva (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_we(i_reg_we),
  .o_reg_rdata(o_reg_rdata), .i_alu_valid(i_alu_valid), .i_alu_op(i_alu_op),
  .i_alu_file(i_alu_file), .i_alu_w(i_alu_w), .i_alu_dest_status(i_alu_dest_status),
  .o_alu_result(o_alu_result), .i_evt_wdt_clear(i_evt_wdt_clear), .i_evt_sleep(i_evt_sleep),
  .i_evt_wdt_timeout(i_evt_wdt_timeout), .i_port_change(i_port_change),
  .i_port_latch(i_port_latch), .o_pullup_enable(o_pullup_enable),
  .o_indirect_bank_base(o_indirect_bank_base), .o_direct_bank_base(o_direct_bank_base),
  .o_status(o_status), .o_option(o_option), .o_int_flags(o_int_flags));

//--- verif/cso_core_status_option_tb_top.sv
// Self-checking bench for the core status and option register bank.
`timescale 1ns/1ps
`include "cso_defs.vh"
module cso_core_status_option_tb_top;
  reg        clk, nrst, we, go, dest, wclr, slp, wto, icyc, wosc, t0pin, epin, pchg, rd_pend;
  reg  [8:0] addr;
  reg  [7:0] wdata, f, w, latch, st, t0a;
  reg  [3:0] op;
  reg  [2:0] fclr;
  reg [15:0] aq[$];
  reg  [7:0] rq[$];
  wire       hit, done, wtick, v, vd;
  wire [3:0] vop;
  wire [7:0] rdata, res, status, option, t0cnt, pull, vf, vw;
  wire [8:0] ibase, dbase;
  wire [2:0] flags;
  integer    seed, err_total, num_checks, i, j, k;

  cso_core_model i_core (.i_core_clk(clk), .i_nrst(nrst), .i_go(go), .i_op(op), .i_file(f),
    .i_w(w), .i_dest(dest), .o_valid(v), .o_op(vop), .o_file(vf), .o_w(vw), .o_dest(vd));
  cso_core_status_option i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_we(we), .o_reg_hit(hit), .o_reg_rdata(rdata),
    .i_alu_valid(v), .i_alu_op(vop), .i_alu_file(vf), .i_alu_w(vw), .i_alu_dest_status(vd),
    .o_alu_result(res), .o_alu_done(done), .i_evt_wdt_clear(wclr), .i_evt_sleep(slp),
    .i_evt_wdt_timeout(wto), .i_instr_cycle_en(icyc), .i_wdt_osc_tick(wosc),
    .i_timer0_ext_clock_pin(t0pin), .i_ext_interrupt_pin(epin), .i_port_change(pchg),
    .i_port_latch(latch), .i_int_flag_clr(fclr), .o_pullup_enable(pull),
    .o_indirect_bank_base(ibase), .o_direct_bank_base(dbase), .o_status(status),
    .o_option(option), .o_timer0_count(t0cnt), .o_wdt_tick(wtick), .o_int_flags(flags));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input [15:0] got, input [15:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task end_of_test;
  begin
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  task tk(input integer n);
  begin
    repeat (n)
    begin
      @(posedge clk);
      go <= 1'b0;
    end
  end
  endtask

  task wr(input [8:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    if (a[6:0] == 7'h03)
      st = {d[7:5], st[4:3], d[2:0]};
  end
  endtask

  task rd(input [8:0] a, input [7:0] x);
  begin
    @(posedge clk);
    addr <= a;
    rq.push_back(x);
    @(posedge clk);
    rd_pend <= 1'b1;
    chk({15'h0000, hit}, {15'h0000, (a[6:0] == 7'h03) || (a[7:0] == 8'h81)});
    @(posedge clk);
    rd_pend <= 1'b0;
  end
  endtask

  // Flags an operation does not touch keep their old value in the model.
  task alu(input [3:0] o, input [7:0] a, input [7:0] b, input ds);
    reg [8:0] s;
    reg [7:0] nb;
    reg [2:0] fl, m;
  begin
    nb = ~b;
    fl = st[2:0];
    m = 3'b100;
    case (o)
      `CSO_OP_ADD: begin s = a + b; fl[1] = (a[3:0] + b[3:0]) > 15; m = 3'b111; end
      `CSO_OP_SUB: begin s = a + nb + 1; fl[1] = (a[3:0] + nb[3:0] + 1) > 15; m = 3'b111; end
      `CSO_OP_AND: s = a & b;
      `CSO_OP_IOR: s = a | b;
      `CSO_OP_XOR: s = a ^ b;
      `CSO_OP_RL: begin s = {a, st[0]}; m = 3'b001; end
      `CSO_OP_RR: begin s = {a[0], st[0], a[7:1]}; m = 3'b001; end
      `CSO_OP_CLEAR: s = 9'h000;
      `CSO_OP_SWAP: begin s = {1'b0, a[3:0], a[7:4]}; m = 3'b000; end
      default: begin s = {1'b0, b}; m = 3'b000; end
    endcase
    fl = {m[2] ? (s[7:0] == 8'h00) : fl[2], fl[1], m[0] ? s[8] : fl[0]};
    if (ds)
      st = {s[7:5], st[4:3], (m != 3'b000) ? fl : s[2:0]};
    else
      st[2:0] = fl;
    aq.push_back({s[7:0], st});
    @(posedge clk);
    go <= 1'b1;
    op <= o;
    f <= a;
    w <= b;
    dest <= ds;
  end
  endtask

  task ev(input [1:0] n);
  begin
    @(posedge clk);
    {wclr, slp, wto} <= 3'b100 >> n;
    st[4:3] = (n == 2) ? {1'b0, st[3]} : {1'b1, n == 0};
    @(posedge clk);
    {wclr, slp, wto} <= 3'b000;
  end
  endtask

  task clr(input [2:0] m);
  begin
    @(posedge clk);
    fclr <= m;
    @(posedge clk);
    fclr <= 3'b000;
  end
  endtask

  // ****************************************
  // Result monitor
  // ****************************************
  always @(posedge clk)
  begin
    if (done === 1'b1)
      chk({res, status}, (aq.size() > 0) ? aq.pop_front() : 16'hxxxx);
    if (rd_pend === 1'b1)
      chk({8'h00, rdata}, {8'h00, (rq.size() > 0) ? rq.pop_front() : 8'hxx});
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 36;
    err_total = 0;
    num_checks = 0;
    {nrst, we, go, dest, wclr, slp, wto, icyc, wosc, t0pin, epin, pchg, rd_pend} = 13'h0000;
    {addr, wdata, f, w, latch, op, fclr} = 48'h0000_0000_0000;
    st = 8'h18;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    tk(3);
    for (i = 0; i < 4; i = i + 1)
      rd({i[1:0], 7'h03}, 8'h18);
    rd(9'h081, 8'hff);
    rd(9'h181, 8'hff);
    wr(9'h181, 8'h5a);
    rd(9'h081, 8'h5a);
    wr(9'h005, 8'h77);
    rd(9'h005, 8'h00);
    wr(9'h183, 8'h00);
    rd(9'h003, st);
    for (i = 2; i >= 0; i = i - 1)
    begin
      ev(i[1:0]);
      wr(9'h103, 8'h18);
      rd(9'h083, st);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(9'h003, {i[2:0], 5'h00});
      tk(1);
      chk({ibase, dbase[8:7]}, {i[2], 8'h00, i[1:0]});
    end
    for (i = 0; i < 20; i = i + 1)
      alu(i % 10, $random(seed), $random(seed), 1'b0);
    alu(`CSO_OP_SUB, 8'h05, 8'h05, 1'b0);
    alu(`CSO_OP_SUB, 8'h40, 8'h41, 1'b0);
    alu(`CSO_OP_ADD, 8'hff, 8'h01, 1'b0);
    alu(`CSO_OP_MOVE, st, 8'hff, 1'b1);
    alu(`CSO_OP_CLEAR, st, 8'h00, 1'b1);
    alu(`CSO_OP_ADD, st, 8'h7c, 1'b1);
    alu(`CSO_OP_RR, st, 8'h00, 1'b1);
    tk(4);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(9'h081, {i[0], 7'h68});
      latch <= $random(seed);
      tk(1);
      chk({8'h00, pull}, {8'h00, i[0] ? 8'h00 : latch});
    end
    for (i = 0; i < 8; i = (i == 2) ? 7 : i + 1)
    begin
      wr(9'h081, 8'hc0 | i[2:0]);
      t0a = t0cnt;
      for (j = 0; j < (4 << i) + 4; j = j + 1)
      begin
        @(posedge clk);
        icyc <= (j < (4 << i));
      end
      chk({8'h00, t0cnt - t0a}, 16'h0002);
    end
    // The prescaler goes to the watchdog here, the only way to count 1:1.
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(9'h081, 8'hc8 | i[2:0]);
      t0a = t0cnt;
      k = 0;
      for (j = 0; j < (2 << i) + 4; j = j + 1)
      begin
        @(posedge clk);
        wosc <= (j < (2 << i));
        icyc <= (j < 2);
        if (wtick === 1'b1)
          k = k + 1;
      end
      chk({8'h00, t0cnt - t0a}, 16'h0002);
      chk(k[15:0], 16'h0002);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(9'h081, {3'b111, i[0], 4'h8});
      t0a = t0cnt;
      for (j = 0; j < 7; j = j + 1)
      begin
        @(posedge clk);
        t0pin <= ~t0pin;
        icyc <= 1'b1;
        tk(6);
      end
      chk({8'h00, t0cnt - t0a}, 16'h0004 - i[15:0]);
      @(posedge clk);
      t0pin <= 1'b0;
      icyc <= 1'b0;
      tk(8);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(9'h081, {1'b1, i[0], 6'h28});
      for (j = 0; j < 2; j = j + 1)
      begin
        @(posedge clk);
        epin <= ~epin;
        tk(8);
        chk({15'h0000, flags[1]}, {15'h0000, i[0] ^ j[0]});
        clr(3'b010);
      end
    end
    // A set arriving with its own clear must win.
    @(posedge clk);
    pchg <= 1'b1;
    fclr <= 3'b001;
    @(posedge clk);
    pchg <= 1'b0;
    fclr <= 3'b000;
    tk(1);
    chk({13'h0000, flags}, 16'h0001);
    clr(3'b001);
    tk(1);
    chk({13'h0000, flags}, 16'h0000);
    wr(9'h081, 8'h08);
    for (j = 0; j < 300 && flags[2] !== 1'b1; j = j + 1)
    begin
      icyc <= 1'b1;
      @(posedge clk);
    end
    icyc <= 1'b0;
    chk({15'h0000, flags[2]}, 16'h0001);
    for (i = 0; i < 50 && (aq.size() + rq.size()) > 0; i = i + 1)
      @(posedge clk);
    if ((aq.size() + rq.size()) > 0)
      chk(16'h0000, 16'h0001);
    end_of_test;
  end
endmodule
